/* verilog/osc_ctrl_defs.svh */
`ifndef OSC_CTRL_DEFS_SVH
`define OSC_CTRL_DEFS_SVH
`define OSC_CTRL_IDX      14'hf86
`define OSC_STAT_IDX      14'hf87
`define OSC_CTRL_RESET    8'ha0
`define OSC_KEY_FIRST     8'he7
`define OSC_KEY_SECOND    8'h18
`define OSC_BIT_PREC_EN   7
`define OSC_BIT_XTL_EN    6
`define OSC_BIT_WDO_EN    5
`define OSC_BIT_SYS_FDE   4
`define OSC_BIT_WDO_FDE   3
`define OSC_SEL_PREC_HIGH 3'h0
`define OSC_SEL_PREC_LOW  3'h1
`define OSC_SEL_XTAL      3'h2
`define OSC_SEL_WDO       3'h3
`define OSC_SEL_EXT       3'h4
`define SYS_FAIL_TIME_US  1000
`define WDO_PERIOD_US     100
`define SYS_FAIL_WDO_EDGES (`SYS_FAIL_TIME_US / `WDO_PERIOD_US)
`define WDO_FAIL_CYCLES   8004
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

/* verilog/osc_ctrl_pkg.sv */
`default_nettype none
package osc_ctrl_pkg;
    typedef enum logic [1:0] {LOCKED, FIRST_KEY, OPEN} unlock_t;
    typedef struct packed {
        logic [7:0]  ctrl;
        unlock_t     unlock;
        logic        forced;
        logic        sysFailed;
        logic        wdoFailed;
        logic        halted;
        logic        sysNmi;
        logic        wdoNmi;
        logic [2:0]  effSel;
        logic [2:0]  wdoSync;
        logic [2:0]  priSync;
        logic [13:0] wdoGap;
        logic [7:0]  priGap;
        logic        awHeld;
        logic [15:0] awAddr;
        logic        wHeld;
        logic [7:0]  wData;
        logic        wStrb0;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } state_t;
endpackage : osc_ctrl_pkg
`default_nettype wire

/* verilog/osc_clock_select.sv */
// Local design decisions: register access over AXI4-Lite and the register addresses.
`include "osc_ctrl_defs.svh"
`default_nettype none
// What this block does
// - control register updates only after writes E7 then 18; next write stores, relocks
// - any other write sequence to the control register leaves it unchanged
// - keys in order and adjacent among control register writes; other register accesses keep the unlock state
// - failure detection may be re-enabled after a successful select write
// - precision oscillator on after reset; only its enable bit stops it
// - precision oscillator supplies high or low rate, chosen by the select field
// - system clock failure raises a nonmaskable event and forces the watchdog oscillator
// - forced switch only when watchdog oscillator enabled and not already selected
// - system clock failure declared below about 1 kHz
// - watchdog oscillator failure raises an event but never switches clocks
// - after watchdog oscillator failure, system clock failure detection stops
// - watchdog oscillator failure after 8004 system clocks with no watchdog edge
// - with detection and the selected source off the block halts until power-on
// - select codes 000 high, 001 low, 010 crystal, 011 watchdog, 100 pin
// - enables in bits 7..3; reset leaves bits 7 and 5 set
module osc_clock_select #(
    parameter int WDO_FAIL_CYCLES = `WDO_FAIL_CYCLES,
    parameter int SYS_FAIL_EDGES  = `SYS_FAIL_WDO_EDGES
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        primaryClkMon,
    input  wire logic        watchdogOscClk,
    output var  logic [2:0]  clockSourceSelect,
    output var  logic        precisionOscEnable,
    output var  logic        crystalOscEnable,
    output var  logic        watchdogOscEnable,
    output var  logic        sysClkFailNmi,
    output var  logic        watchdogOscFailNmi,
    output var  logic        deviceHalted
);
    import osc_ctrl_pkg::*;

    state_t state_ff;
    state_t nxt_state;
    logic   wrPerform;
    logic   ctrlWr;
    logic   priEdge;
    logic   wdoEdge;
    logic   recoverOk;
    logic   sysTrip;
    logic   wdoTrip;

    function automatic logic srcEnabled(input logic [7:0] c, input logic [2:0] sel);
        logic en;
        en = 1'b1;
        unique case (sel)
            `OSC_SEL_PREC_HIGH, `OSC_SEL_PREC_LOW: en = c[`OSC_BIT_PREC_EN];
            `OSC_SEL_XTAL: en = c[`OSC_BIT_XTL_EN];
            `OSC_SEL_WDO:  en = c[`OSC_BIT_WDO_EN];
            default:       en = (sel == `OSC_SEL_EXT);
        endcase
        return en;
    endfunction : srcEnabled

    function automatic logic hits(input logic [15:0] a, input logic [13:0] idx);
        return a[15:2] == idx && a[1:0] == 2'h0;
    endfunction : hits

    assign wrPerform = state_ff.awHeld && state_ff.wHeld && !state_ff.bvalid;
    assign ctrlWr    = wrPerform && hits(state_ff.awAddr, `OSC_CTRL_IDX) && state_ff.wStrb0;
    assign priEdge   = state_ff.priSync[2] ^ state_ff.priSync[1];
    assign wdoEdge   = state_ff.wdoSync[2] ^ state_ff.wdoSync[1];
    assign recoverOk = state_ff.ctrl[`OSC_BIT_WDO_EN] && state_ff.ctrl[2:0] != `OSC_SEL_WDO;
    assign sysTrip   = state_ff.ctrl[`OSC_BIT_SYS_FDE] && !state_ff.wdoFailed && !state_ff.sysFailed
                       && 32'(state_ff.priGap) >= SYS_FAIL_EDGES;
    assign wdoTrip   = state_ff.ctrl[`OSC_BIT_WDO_FDE] && !state_ff.wdoFailed
                       && 32'(state_ff.wdoGap) >= WDO_FAIL_CYCLES;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.sysNmi = 1'b0;
        nxt_state.wdoNmi = 1'b0;
        nxt_state.wdoSync = {state_ff.wdoSync[1:0], watchdogOscClk};
        nxt_state.priSync = {state_ff.priSync[1:0], primaryClkMon};
        // bus side: latch address and data in either order
        if (s_axi_awvalid && state_ff.awready) begin
            nxt_state.awHeld = 1'b1;
            nxt_state.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_ff.wready) begin
            nxt_state.wHeld  = 1'b1;
            nxt_state.wData  = s_axi_wdata[7:0];
            nxt_state.wStrb0 = s_axi_wstrb[0];
        end
        if (state_ff.bvalid && s_axi_bready) begin
            nxt_state.bvalid = 1'b0;
        end
        if (wrPerform) begin
            nxt_state.awHeld = 1'b0;
            nxt_state.wHeld  = 1'b0;
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp  = (hits(state_ff.awAddr, `OSC_CTRL_IDX) || hits(state_ff.awAddr, `OSC_STAT_IDX))
                               ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (ctrlWr) begin
            unique case (state_ff.unlock)
                LOCKED: begin
                    nxt_state.unlock = (state_ff.wData == `OSC_KEY_FIRST) ? FIRST_KEY : LOCKED;
                end
                FIRST_KEY: begin
                    if (state_ff.wData == `OSC_KEY_SECOND) begin
                        nxt_state.unlock = OPEN;
                    end else if (state_ff.wData == `OSC_KEY_FIRST) begin
                        nxt_state.unlock = FIRST_KEY;
                    end else begin
                        nxt_state.unlock = LOCKED;
                    end
                end
                OPEN: begin
                    // precision oscillator stays as written; changing select never touches its enable
                    nxt_state.ctrl      = state_ff.wData;
                    nxt_state.unlock    = LOCKED;
                    nxt_state.forced    = 1'b0;
                    nxt_state.sysFailed = 1'b0;
                    nxt_state.priGap    = 8'h00;
                end
            endcase
        end
        // failure watch: primary edges counted against watchdog edges
        if (priEdge) begin
            nxt_state.priGap = 8'h00;
        end else if (wdoEdge && 32'(state_ff.priGap) < SYS_FAIL_EDGES) begin
            nxt_state.priGap = state_ff.priGap + 8'h01;
        end
        if (wdoEdge) begin
            nxt_state.wdoGap = 14'h0000;
        end else if (32'(state_ff.wdoGap) < WDO_FAIL_CYCLES) begin
            nxt_state.wdoGap = state_ff.wdoGap + 14'h0001;
        end
        if (sysTrip) begin
            nxt_state.sysNmi    = 1'b1;
            nxt_state.sysFailed = 1'b1;
            if (recoverOk) begin
                nxt_state.forced = 1'b1;
            end else begin
                nxt_state.halted = 1'b1;
            end
        end
        if (wdoTrip) begin
            nxt_state.wdoNmi    = 1'b1;
            nxt_state.wdoFailed = 1'b1;
        end
        if (!state_ff.ctrl[`OSC_BIT_SYS_FDE] && !srcEnabled(state_ff.ctrl, state_ff.effSel)) begin
            nxt_state.halted = 1'b1;
        end
        nxt_state.effSel = nxt_state.forced ? `OSC_SEL_WDO : nxt_state.ctrl[2:0];
        // read side
        if (state_ff.rvalid && s_axi_rready) begin
            nxt_state.rvalid = 1'b0;
        end
        if (s_axi_arvalid && state_ff.arready) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp  = `RESP_OKAY;
            if (hits(s_axi_araddr, `OSC_CTRL_IDX)) begin
                nxt_state.rdata = {24'h000000, state_ff.ctrl};
            end else if (hits(s_axi_araddr, `OSC_STAT_IDX)) begin
                nxt_state.rdata = {21'h00000, state_ff.effSel, 2'b00, 2'(state_ff.unlock), state_ff.halted,
                                   state_ff.forced, state_ff.wdoFailed, state_ff.sysFailed};
            end else begin
                nxt_state.rdata = 32'h00000000;
                nxt_state.rresp = `RESP_SLVERR;
            end
        end
        nxt_state.awready = !nxt_state.awHeld && !nxt_state.bvalid;
        nxt_state.wready  = !nxt_state.wHeld && !nxt_state.bvalid;
        nxt_state.arready = !nxt_state.rvalid;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff        <= '0;
            state_ff.ctrl   <= `OSC_CTRL_RESET;
            state_ff.unlock <= LOCKED;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign s_axi_awready      = state_ff.awready;
    assign s_axi_wready       = state_ff.wready;
    assign s_axi_bvalid       = state_ff.bvalid;
    assign s_axi_bresp        = state_ff.bresp;
    assign s_axi_arready      = state_ff.arready;
    assign s_axi_rvalid       = state_ff.rvalid;
    assign s_axi_rdata        = state_ff.rdata;
    assign s_axi_rresp        = state_ff.rresp;
    assign clockSourceSelect  = state_ff.effSel;
    assign precisionOscEnable = state_ff.ctrl[`OSC_BIT_PREC_EN];
    assign crystalOscEnable   = state_ff.ctrl[`OSC_BIT_XTL_EN];
    assign watchdogOscEnable  = state_ff.ctrl[`OSC_BIT_WDO_EN];
    assign sysClkFailNmi      = state_ff.sysNmi;
    assign watchdogOscFailNmi = state_ff.wdoNmi;
    assign deviceHalted       = state_ff.halted;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_open_write_stores;
        (ctrlWr && state_ff.unlock == OPEN) |=> (state_ff.ctrl == $past(state_ff.wData)) && state_ff.unlock == LOCKED;
    endproperty
    a_open_write_stores: assert property (p_open_write_stores) else $error("unlocked write not stored");

    property p_locked_keeps;
        (state_ff.unlock != OPEN) |=> $stable(state_ff.ctrl);
    endproperty
    a_locked_keeps: assert property (p_locked_keeps) else $error("locked register changed");

    property p_other_keeps_unlock;
        (!ctrlWr) |=> $stable(state_ff.unlock);
    endproperty
    a_other_keeps_unlock: assert property (p_other_keeps_unlock) else $error("unlock state lost");

    property p_reenable_detect;
        (ctrlWr && state_ff.unlock == OPEN && state_ff.wData[`OSC_BIT_SYS_FDE]) |=> state_ff.ctrl[`OSC_BIT_SYS_FDE];
    endproperty
    a_reenable_detect: assert property (p_reenable_detect) else $error("detect enable not taken");

    property p_prec_holds;
        (state_ff.ctrl[`OSC_BIT_PREC_EN] && !ctrlWr) |=> state_ff.ctrl[`OSC_BIT_PREC_EN];
    endproperty
    a_prec_holds: assert property (p_prec_holds) else $error("precision oscillator dropped");

    property p_low_rate;
        (ctrlWr && state_ff.unlock == OPEN && state_ff.wData[2:0] == `OSC_SEL_PREC_LOW)
            |=> clockSourceSelect == 3'h1;
    endproperty
    a_low_rate: assert property (p_low_rate) else $error("low rate not selected");

    property p_failover;
        (sysTrip && recoverOk) |=> sysClkFailNmi && clockSourceSelect == `OSC_SEL_WDO;
    endproperty
    a_failover: assert property (p_failover) else $error("no failover to watchdog oscillator");

    property p_no_failover;
        (sysTrip && !recoverOk) |=> !state_ff.forced;
    endproperty
    a_no_failover: assert property (p_no_failover) else $error("failover without usable watchdog");

    property p_wdo_no_switch;
        watchdogOscFailNmi |-> !$rose(state_ff.forced);
    endproperty
    a_wdo_no_switch: assert property (p_wdo_no_switch) else $error("watchdog failure switched clock");

    property p_no_sys_after_wdo;
        state_ff.wdoFailed |=> !sysClkFailNmi;
    endproperty
    a_no_sys_after_wdo: assert property (p_no_sys_after_wdo) else $error("system detect after wdo fail");

    property p_wdo_count;
        (state_ff.ctrl[`OSC_BIT_WDO_FDE] && !state_ff.wdoFailed && 32'(state_ff.wdoGap) == WDO_FAIL_CYCLES)
            |=> watchdogOscFailNmi;
    endproperty
    a_wdo_count: assert property (p_wdo_count) else $error("watchdog failure not declared");

    property p_halt_sticky;
        deviceHalted |=> deviceHalted;
    endproperty
    a_halt_sticky: assert property (p_halt_sticky) else $error("halt released without reset");

    property p_pulse;
        sysClkFailNmi |=> !sysClkFailNmi;
    endproperty
    a_pulse: assert property (p_pulse) else $error("system failure event longer than one cycle");

    property p_wdo_pulse;
        watchdogOscFailNmi |=> !watchdogOscFailNmi;
    endproperty
    a_wdo_pulse: assert property (p_wdo_pulse) else $error("watchdog failure event longer than one cycle");

    property p_sys_gap_reached;
        sysClkFailNmi |-> 32'($past(state_ff.priGap)) >= SYS_FAIL_EDGES;
    endproperty
    a_sys_gap_reached: assert property (p_sys_gap_reached) else $error("system failure before gap limit");

    c_unlock_write: cover property (ctrlWr && state_ff.unlock == OPEN);
    c_failover: cover property (sysClkFailNmi && clockSourceSelect == `OSC_SEL_WDO);
    c_wdo_fail: cover property (watchdogOscFailNmi);
    c_halt: cover property ($rose(deviceHalted));
endmodule : osc_clock_select
`default_nettype wire

/* test/osc_source_model.sv */
`default_nettype none
module osc_source_model (
    input  wire logic primaryRun,
    input  wire logic watchdogRun,
    input  wire logic watchdogOscEnable,
    output var  logic primaryClkMon,
    output var  logic watchdogOscClk
);
    timeunit 1ns;
    timeprecision 100ps;
    // periods unrelated to clk; a stopped source freezes at its last level
    initial primaryClkMon = 1'b0;
    initial watchdogOscClk = 1'b0;
    always #17 if (primaryRun) primaryClkMon = ~primaryClkMon;
    // the watchdog oscillator only oscillates while it is enabled
    always #43 if (watchdogRun && watchdogOscEnable) watchdogOscClk = ~watchdogOscClk;
endmodule : osc_source_model
`default_nettype wire

/* test/system_clock_select_and_failure_recovery_test.sv */
`include "osc_ctrl_defs.svh"
`default_nettype none
module system_clock_select_and_failure_recovery_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int          WFC    = 40;
    localparam logic [15:0] CTRL_A = {`OSC_CTRL_IDX, 2'b00};
    localparam logic [15:0] STAT_A = {`OSC_STAT_IDX, 2'b00};
    logic        clk = 1'b0, rstn = 1'b0;
    logic [15:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        primaryRun = 1'b1, watchdogRun = 1'b1, primaryClkMon, watchdogOscClk;
    logic [2:0]  sel;
    logic        precEn, xtalEn, wdoEn, sysNmi, wdoNmi, halted;
    int          failCount = 0, nCompared = 0, n;

    always #5 clk = ~clk;

    osc_source_model i_osc_source_model (.primaryRun(primaryRun), .watchdogRun(watchdogRun),
        .watchdogOscEnable(wdoEn), .primaryClkMon(primaryClkMon), .watchdogOscClk(watchdogOscClk));

    osc_clock_select #(.WDO_FAIL_CYCLES(WFC), .SYS_FAIL_EDGES(3)) i_osc_clock_select (
        .clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .primaryClkMon(primaryClkMon),
        .watchdogOscClk(watchdogOscClk), .clockSourceSelect(sel), .precisionOscEnable(precEn),
        .crystalOscEnable(xtalEn), .watchdogOscEnable(wdoEn), .sysClkFailNmi(sysNmi),
        .watchdogOscFailNmi(wdoNmi), .deviceHalted(halted));

    task automatic results;
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic axiWrite(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 100);
        check("bresp", 32'(er), 32'(bresp));
        bready <= 1'b0;
        if (k >= 100) begin
            failCount++;
            results();
        end
    endtask : axiWrite

    task automatic readCheck(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 100);
        check("rdata", exp, rdata);
        check("rresp", 32'(er), 32'(rresp));
        rready <= 1'b0;
        if (k >= 100) begin
            failCount++;
            results();
        end
    endtask : readCheck

    task automatic ctrlWrite(input logic [7:0] d);
        axiWrite(CTRL_A, `OSC_KEY_FIRST, `RESP_OKAY);
        axiWrite(CTRL_A, `OSC_KEY_SECOND, `RESP_OKAY);
        axiWrite(CTRL_A, d, `RESP_OKAY);
        @(posedge clk);
        #1;
    endtask : ctrlWrite

    // returns limit when no pulse arrived
    task automatic waitNmi(input bit wdo, input int limit, output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while ((wdo ? wdoNmi : sysNmi) !== 1'b1 && k < limit);
        @(posedge clk);
        #1;
        check("nmi width", 32'h0, 32'({sysNmi, wdoNmi}));
    endtask : waitNmi

    task automatic doReset;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
    endtask : doReset

    initial begin
        doReset();
        check("reset enables", 32'h5, 32'({precEn, xtalEn, wdoEn}));
        readCheck(CTRL_A, 32'(`OSC_CTRL_RESET), `RESP_OKAY);
        axiWrite(CTRL_A, 8'h5a, `RESP_OKAY);
        readCheck(CTRL_A, 32'h0a0, `RESP_OKAY);
        axiWrite(CTRL_A, `OSC_KEY_FIRST, `RESP_OKAY);
        readCheck(STAT_A, 32'h10, `RESP_OKAY);
        axiWrite(16'h0000, 8'h00, `RESP_SLVERR);
        axiWrite(CTRL_A, `OSC_KEY_SECOND, `RESP_OKAY);
        readCheck(STAT_A, 32'h20, `RESP_OKAY);
        axiWrite(CTRL_A, 8'h81, `RESP_OKAY);
        #1;
        check("low rate select", 32'h1, 32'(sel));
        check("watchdog enable off", 32'h0, 32'(wdoEn));
        axiWrite(CTRL_A, 8'ha0, `RESP_OKAY);
        readCheck(CTRL_A, 32'h81, `RESP_OKAY);
        axiWrite(CTRL_A, `OSC_KEY_FIRST, `RESP_OKAY);
        axiWrite(CTRL_A, 8'h55, `RESP_OKAY);
        axiWrite(CTRL_A, `OSC_KEY_SECOND, `RESP_OKAY);
        axiWrite(CTRL_A, 8'h00, `RESP_OKAY);
        readCheck(CTRL_A, 32'h81, `RESP_OKAY);
        readCheck(16'h0000, 32'h0, `RESP_SLVERR);
        // crystal and watchdog enabled ahead of selection, detection off while switching
        for (int s = 0; s < 5; s++) begin
            ctrlWrite(8'he0 | 8'(s));
            check("select", 32'(s), 32'(sel));
            check("precision osc kept on", 32'h1, 32'(precEn));
            check("crystal enable", 32'h1, 32'(xtalEn));
        end
        ctrlWrite(8'ha0);
        ctrlWrite(8'hb0);
        primaryRun <= 1'b0;
        waitNmi(1'b0, 300, n);
        check("sys fail seen", 32'h1, 32'(n < 300));
        check("forced select", 32'(`OSC_SEL_WDO), 32'(sel));
        readCheck(STAT_A, 32'h305, `RESP_OKAY);
        primaryRun <= 1'b1;
        ctrlWrite(8'ha0);
        check("select restored", 32'h0, 32'(sel));
        ctrlWrite(8'ha8);
        watchdogRun <= 1'b0;
        waitNmi(1'b1, 300, n);
        check("wdo fail delay", 32'h1, 32'(n >= WFC - 12 && n <= WFC + 8));
        check("no switch on wdo fail", 32'h0, 32'(sel));
        watchdogRun <= 1'b1;
        ctrlWrite(8'hb0);
        primaryRun <= 1'b0;
        waitNmi(1'b0, 200, n);
        check("sys detect after wdo fail", 32'd200, 32'(n));
        check("select kept", 32'h0, 32'(sel));
        primaryRun <= 1'b1;
        doReset();
        ctrlWrite(8'hb3);
        primaryRun <= 1'b0;
        waitNmi(1'b0, 300, n);
        check("sys fail on wdo clock", 32'h1, 32'(n < 300));
        check("no forced switch", 32'h13, 32'({halted, 1'b0, sel}));
        primaryRun <= 1'b1;
        doReset();
        check("halt cleared", 32'h0, 32'(halted));
        ctrlWrite(8'h00);
        repeat (2) @(posedge clk);
        #1;
        check("all sources off", 32'h1, 32'(halted));
        results();
    end
endmodule : system_clock_select_and_failure_recovery_test
`default_nettype wire
